// ==== rtl/cgp_pkg.sv ====
// Purpose : Shared constants for the configurable pad block
// Assumes : One system clock, synchronous active-high reset
// Notes   : Pad index 0..9 are primary pads 1..10; 10 and up are extra pads
package cgp_pkg;
  // ==========================================================================
  // Pad counts
  localparam int          CGP_NUM_PRIMARY = 10;     // Always-GPIO pads
  localparam int          CGP_NUM_EXTRA   = 17;     // Interface pads that can be released
  localparam int          CGP_NUM_PADS    = CGP_NUM_PRIMARY + CGP_NUM_EXTRA;
  // ==========================================================================
  // Mode encoding, two bits per pad
  localparam logic [1:0]  CGP_MODE_IN     = 2'h0;   // Digital input
  localparam logic [1:0]  CGP_MODE_OUT    = 2'h1;   // Push-pull output
  localparam logic [1:0]  CGP_MODE_ALT    = 2'h2;   // Internal function drives pad
  // Interrupt trigger select, two bits per pad
  localparam logic [1:0]  CGP_TRIG_RISE   = 2'h0;
  localparam logic [1:0]  CGP_TRIG_FALL   = 2'h1;
  localparam logic [1:0]  CGP_TRIG_HIGH   = 2'h2;
  localparam logic [1:0]  CGP_TRIG_LOW    = 2'h3;
  // ==========================================================================
  // Wake-capable pads: pad numbers 1, 4, 5, 8 -> index 0, 3, 4, 7
  localparam logic [CGP_NUM_PADS-1:0] CGP_WAKE_MASK = 27'h0000099;
  // Reset values
  localparam logic [1:0]  CGP_MODE_RST    = CGP_MODE_IN;
  localparam logic        CGP_BIT_RST     = 1'h0;
  localparam logic        CGP_SYNC_RST    = 1'h0;
  // Cycles after reset before pad events count: two sync stages plus edge history
  localparam int          CGP_ARM_STAGES  = 3;
endpackage : cgp_pkg

// ==== rtl/cgp_pads.sv ====
// Purpose : Configurable general-purpose pad block with interrupt and wake
// Assumes : Pad inputs are asynchronous; control ports are on clk_sys
// Notes   : Output enables are active low (low = module drives the pad)
//
// How it works
// - Each pad selects input, output or alternate mode
// - Input mode reads synchronised pad level
// - Output mode drives and reads back written value
// - Alternate mode hands pad to internal function
// - Primary pads one to ten always GPIO
// - Extra pads keep interface function until released
// - Any input pad can raise interrupt
// - Only pads 1,4,5,8 may wake module
// - Output drives high and low, push-pull
// - Pads one to ten offer I2C alternate
`timescale 1ns/1ps
module cgp_pads
  import cgp_pkg::*;
#(
  parameter int NP = CGP_NUM_PADS,             // Total pad count
  parameter int NPRI = CGP_NUM_PRIMARY         // Primary pad count
) (
  input  wire logic              clk_sys,            // System clock, 125 MHz
  input  wire logic              sys_rst,            // Synchronous reset, active high
  input  wire logic [2*NP-1:0]   mode_sel,           // Two bits of mode per pad
  input  wire logic [NP-1:0]     out_value,          // Software output values
  input  wire logic [NP-1:0]     gpio_release,       // Extra pads: 1 releases interface function
  input  wire logic [NP-1:0]     i2c_select,         // Primary pads: 1 picks I2C as alternate
  input  wire logic [NP-1:0]     alt_out,            // Interface/firmware function output level
  input  wire logic [NP-1:0]     alt_oe_n,           // Interface function drive, low = drive
  input  wire logic [NP-1:0]     i2c_out,            // I2C function output level
  input  wire logic [NP-1:0]     i2c_oe_n,           // I2C function drive, low = drive
  input  wire logic [NP-1:0]     irq_enable,         // Per-pad interrupt enable
  input  wire logic [2*NP-1:0]   irq_trigger,        // Per-pad trigger select
  input  wire logic [NP-1:0]     irq_clear,          // Write-one-to-clear pending
  input  wire logic              sleep_active,       // Module is asleep
  input  wire logic [NP-1:0]     pad_in,             // Pad input level, asynchronous
  output logic      [NP-1:0]     pad_out,            // Pad output level
  output logic      [NP-1:0]     pad_oe_n,           // Pad output enable, low = drive
  output logic      [NP-1:0]     read_value,         // Level read by software
  output logic      [NP-1:0]     alt_in,             // Pad level handed to internal functions
  output logic      [NP-1:0]     irq_pending,        // Sticky pending flags
  output logic                   irq_any,            // Any enabled pending flag
  output logic                   wake_request        // Wake request to power control
);
  // ==========================================================================
  // Input synchronisers: first stage is read only by the second
  logic [NP-1:0] sync_a;        // First stage, metastability catcher
  logic [NP-1:0] sync_b;        // Second stage, safe for logic
  logic [NP-1:0] sync_prev;     // Previous level for edge detection
  logic [NP-1:0] next_sync_a;
  logic [NP-1:0] next_sync_b;
  logic [NP-1:0] next_sync_prev;
  // Reset hold-off for pad events: ones shift in after reset, and only the
  // top bit opens the event path. Until then the emptied chain holds zeros
  // rather than pad levels, so a pad idling high would look like a rise.
  // Trade-off: a real pad change in the first cycles after reset is lost.
  logic [CGP_ARM_STAGES-1:0] armed;
  logic [CGP_ARM_STAGES-1:0] next_armed;

  // Next values of the synchroniser chain
  always_comb begin
    next_sync_a    = pad_in;
    next_sync_b    = sync_a;
    next_sync_prev = sync_b;
    next_armed     = {armed[CGP_ARM_STAGES-2:0], 1'b1};
  end

  // Register the chain
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_prev <= '0;
      armed     <= '0;
    end else begin
      sync_a    <= next_sync_a;
      sync_b    <= next_sync_b;
      sync_prev <= next_sync_prev;
      armed     <= next_armed;
    end
  end

  // ==========================================================================
  // Pad drive and read path
  logic [NP-1:0] next_pad_out;
  logic [NP-1:0] next_pad_oe_n;
  logic [NP-1:0] next_read_value;
  logic [NP-1:0] next_alt_in;
  logic [NP-1:0] is_input;      // Pad currently acts as a GPIO input
  logic [NP-1:0] is_gpio;       // Pad is free for GPIO use

  // Per-pad mode decode; one generate for all pads
  for (genvar p = 0; p < NP; p++) begin : g_pad
    logic [1:0] md;             // This pad's mode
    assign md = mode_sel[2*p +: 2];
    // Primary pads are GPIO by nature; extra pads only when released
    if (p < NPRI) begin : g_pri
      assign is_gpio[p] = 1'b1;
    end else begin : g_ext
      assign is_gpio[p] = gpio_release[p];
    end
    always_comb begin
      next_alt_in[p] = sync_b[p];
      if (!is_gpio[p] || md == CGP_MODE_ALT) begin
        // Internal function owns the pad; I2C only on primary pads
        if (p < NPRI && i2c_select[p] && is_gpio[p]) begin
          next_pad_out[p]  = i2c_out[p];
          next_pad_oe_n[p] = i2c_oe_n[p];
        end else begin
          next_pad_out[p]  = alt_out[p];
          next_pad_oe_n[p] = alt_oe_n[p];
        end
        next_read_value[p] = sync_b[p];
        is_input[p]        = 1'b0;
      end else if (md == CGP_MODE_OUT) begin
        // Push-pull: always driven, both levels
        next_pad_out[p]    = out_value[p];
        next_pad_oe_n[p]   = 1'b0;
        next_read_value[p] = out_value[p];
        is_input[p]        = 1'b0;
      end else begin
        // Input, and the unused fourth code falls back to input for safety
        next_pad_out[p]    = 1'b0;
        next_pad_oe_n[p]   = 1'b1;
        next_read_value[p] = sync_b[p];
        is_input[p]        = 1'b1;
      end
    end
  end

  // Register the pad outputs; reset floats every pad as an input, released or not
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_out    <= '0;
      pad_oe_n   <= '1;
      read_value <= '0;
      alt_in     <= '0;
    end else begin
      pad_out    <= next_pad_out;
      pad_oe_n   <= next_pad_oe_n;
      read_value <= next_read_value;
      alt_in     <= next_alt_in;
    end
  end

  // ==========================================================================
  // Interrupt detection and sticky flags
  logic [NP-1:0] raw_hit;       // Trigger decode before the reset hold-off
  logic [NP-1:0] hit;           // Trigger seen this cycle
  logic [NP-1:0] next_pending;
  logic          next_irq_any;
  logic          next_wake;

  // Trigger decode per pad
  for (genvar q = 0; q < NP; q++) begin : g_irq
    always_comb begin
      case (irq_trigger[2*q +: 2])
        CGP_TRIG_RISE: raw_hit[q] = sync_b[q] & ~sync_prev[q];
        CGP_TRIG_FALL: raw_hit[q] = ~sync_b[q] & sync_prev[q];
        CGP_TRIG_HIGH: raw_hit[q] = sync_b[q];
        default:       raw_hit[q] = ~sync_b[q];
      endcase
    end
  end

  // Events count only once the chain and edge history hold real pad levels
  assign hit = raw_hit & {NP{armed[CGP_ARM_STAGES-1]}};

  // Set wins over clear so a same-cycle event is never lost
  always_comb begin
    next_pending = (irq_pending & ~irq_clear)
                 | (hit & is_input & irq_enable);
    next_irq_any = |(next_pending & irq_enable);
    // Only wake-capable pads are seen while asleep
    next_wake    = sleep_active
                 & (|(next_pending & irq_enable & NP'(CGP_WAKE_MASK)));
  end

  // Register flags and summaries
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_pending  <= '0;
      irq_any      <= CGP_BIT_RST;
      wake_request <= CGP_BIT_RST;
    end else begin
      irq_pending  <= next_pending;
      irq_any      <= next_irq_any;
      wake_request <= next_wake;
    end
  end

  // ==========================================================================
  // Assertions
  output_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_sel[2*9 +: 2] == CGP_MODE_OUT) |=> (!pad_oe_n[9] && pad_out[9] == $past(out_value[9])))
    else $error("output pad not driving written value");
  output_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_sel[1:0] == CGP_MODE_OUT) |=> read_value[0] == $past(out_value[0]))
    else $error("output readback wrong");
  input_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_sel[1:0] == CGP_MODE_IN) |=> (pad_oe_n[0] && read_value[0] == $past(sync_b[0])))
    else $error("input pad not reading level");
  alt_owns_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_sel[2*2 +: 2] == CGP_MODE_ALT && !i2c_select[2]) |=> pad_oe_n[2] == $past(alt_oe_n[2]))
    else $error("alternate function not driving pad");
  extra_default_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !gpio_release[NPRI] |=> pad_out[NPRI] == $past(alt_out[NPRI]))
    else $error("extra pad not on interface function");
  i2c_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_sel[2*2 +: 2] == CGP_MODE_ALT && i2c_select[2]) |=> pad_oe_n[2] == $past(i2c_oe_n[2]))
    else $error("i2c alternate not routed");
  pend_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irq_pending[0] && !irq_clear[0]) |=> irq_pending[0])
    else $error("pending flag dropped without clear");
  pend_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hit[0] && is_input[0] && irq_enable[0]) |=> irq_pending[0])
    else $error("input event did not set pending");
  wake_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wake_request |-> $past(sleep_active)
                     && |(($past(irq_pending) | $past(hit)) & $past(irq_enable) & NP'(CGP_WAKE_MASK)))
    else $error("wake from non-wake pad");
  primary_gpio_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_sel[2*9 +: 2] == CGP_MODE_IN) |=> pad_oe_n[9])
    else $error("primary pad not free as gpio");
  wake_cov: cover property (@(posedge clk_sys) disable iff (sys_rst) sleep_active ##1 wake_request);
  irq_cov: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(irq_any));
  clr_cov: cover property (@(posedge clk_sys) disable iff (sys_rst) irq_pending[0] ##1 !irq_pending[0]);
  rel_cov: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(gpio_release[NPRI+2]));
endmodule : cgp_pads

// ==== sim/cgp_board.sv ====
// Purpose : Carrier-board device on the pads, resolves each wire level
// Assumes : Bench avoids driving a pad that the module drives
// Notes   : A pad nobody drives has no pull, so it toggles every cycle
`timescale 1ns/1ps
module cgp_board
  import cgp_pkg::*;
(
  input  wire logic                    clk_sys,    // Clock for float memory
  input  wire logic [CGP_NUM_PADS-1:0] pad_out,    // Module level
  input  wire logic [CGP_NUM_PADS-1:0] pad_oe_n,   // Module drive, low = drive
  input  wire logic [CGP_NUM_PADS-1:0] ext_level,  // Board level
  input  wire logic [CGP_NUM_PADS-1:0] ext_en,     // Board drive enable
  output logic      [CGP_NUM_PADS-1:0] pad_in      // Resolved wire level
);
  logic [CGP_NUM_PADS-1:0] last = '0;              // Last wire level per pad
  // ==========================================================================
  // Wire resolution; contention shows unknown so a double drive is never hidden
  always_comb begin
    for (int i = 0; i < CGP_NUM_PADS; i++) begin
      pad_in[i] = (!pad_oe_n[i] && ext_en[i]) ? 1'bx : !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_level[i] : ~last[i];
    end
  end
  always_ff @(posedge clk_sys) last <= pad_in;
endmodule : cgp_board

// ==== sim/tb.sv ====
// Purpose : Self-checking bench for the pad block
// Assumes : Inputs change 1 ns after the rising edge
// Notes   : Four cycles cover the three-edge input synchroniser
`timescale 1ns/1ps
module tb
  import cgp_pkg::*;
;
  localparam int N = CGP_NUM_PADS;
  typedef struct { int p; logic [1:0] m; logic ov, rel, i2c, ext, eoe, eout, erd; } cgp_row_t;
  logic clk_sys, sys_rst, sleep_active;
  logic [2*N-1:0] mode_sel, irq_trigger;
  logic [N-1:0] out_value, gpio_release, i2c_select, irq_enable, irq_clear, pad_in, ext_level, ext_en;
  logic [N-1:0] pad_out, pad_oe_n, read_value, irq_pending;
  logic [N-1:0] alt_out, alt_oe_n, i2c_out, i2c_oe_n, alt_in;
  logic irq_any, wake_request;
  int err_total = 0, tests_run = 0;
  cgp_row_t rows [9];
  int pl [6] = '{0, 3, 4, 7, 1, 0};                // Pads for interrupt runs
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
  cgp_pads dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .mode_sel(mode_sel), .out_value(out_value),
    .gpio_release(gpio_release), .i2c_select(i2c_select), .alt_out(alt_out), .alt_oe_n(alt_oe_n),
    .i2c_out(i2c_out), .i2c_oe_n(i2c_oe_n), .irq_enable(irq_enable), .irq_trigger(irq_trigger),
    .irq_clear(irq_clear), .sleep_active(sleep_active), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .read_value(read_value), .alt_in(alt_in), .irq_pending(irq_pending),
    .irq_any(irq_any), .wake_request(wake_request));
  cgp_board board (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext_level),
    .ext_en(ext_en), .pad_in(pad_in));
  // ==========================================================================
  // Clock and watchdog; the watchdog at 20000 cycles is far beyond the 164 cycles used
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #(20000 * 8);
    err_total++;
    print_verdict();
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ==========================================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1; sleep_active = 1'b0; mode_sel = '0; irq_trigger = '0; out_value = '0;
    gpio_release = '0; i2c_select = '0; irq_enable = '0; irq_clear = '0; ext_level = '0; ext_en = 27'h00003FF;
    alt_out = '1;
    alt_oe_n = '0;
    i2c_out = '0;
    i2c_oe_n = '1;
    // Rows: pad, mode, value, release, I2C, board level, expected enable, level, read
    rows = '{'{0, CGP_MODE_IN, 0, 0, 0, 1, 1, 0, 1}, '{9, CGP_MODE_OUT, 1, 0, 0, 0, 0, 1, 1},
             '{0, CGP_MODE_OUT, 0, 0, 0, 1, 0, 0, 0}, '{5, 2'h3, 0, 0, 0, 1, 1, 0, 1},
             '{2, CGP_MODE_ALT, 0, 0, 0, 0, 0, 1, 1}, '{2, CGP_MODE_ALT, 0, 0, 1, 0, 1, 0, 0},
             '{12, CGP_MODE_IN, 0, 0, 0, 1, 0, 1, 1}, '{12, CGP_MODE_OUT, 0, 1, 0, 1, 0, 0, 0},
             '{26, CGP_MODE_IN, 0, 1, 0, 1, 1, 0, 1}};
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    `CHK(pad_oe_n, {N{1'b1}})
    `CHK(irq_pending, {N{1'b0}})
    // Mode table: input, output both levels, alternate, I2C, extra pad release
    foreach (rows[r]) begin
      mode_sel = '0; out_value = '0; gpio_release = '0; i2c_select = '0; ext_en = '0;
      mode_sel[2*rows[r].p +: 2] = rows[r].m;
      out_value[rows[r].p] = rows[r].ov;
      gpio_release[rows[r].p] = rows[r].rel;
      i2c_select[rows[r].p] = rows[r].i2c;
      ext_level[rows[r].p] = rows[r].ext;
      // Board lets go first and drives again only once the new mode stands
      step(1);
      ext_en = 27'h00003FF;
      ext_en[rows[r].p] = rows[r].eoe;
      step(3);
      `CHK(pad_oe_n[rows[r].p], rows[r].eoe)
      if (!rows[r].eoe) `CHK(pad_out[rows[r].p], rows[r].eout)
      `CHK(read_value[rows[r].p], rows[r].erd)
    end
    // Every trigger kind, wake only from pads 1, 4, 5, 8 while asleep
    mode_sel = '0;
    ext_en = 27'h00003FF;
    foreach (pl[i]) begin
      irq_trigger[2*pl[i] +: 2] = 2'(i % 4);
      ext_level[pl[i]] = i[0];
      sleep_active = (i != 5);
      step(4);
      irq_enable[pl[i]] = 1'b1;
      step(2);
      `CHK(irq_pending[pl[i]], 1'b0)
      ext_level[pl[i]] = ~i[0];
      step(4);
      `CHK(irq_pending[pl[i]], 1'b1)
      `CHK(irq_any, 1'b1)
      `CHK(wake_request, 1'((i != 5) && (pl[i] != 1)))
      ext_level[pl[i]] = i[0];
      step(4);
      irq_clear[pl[i]] = 1'b1;
      step(1);
      irq_clear[pl[i]] = 1'b0;
      step(1);
      `CHK(irq_pending[pl[i]], 1'b0)
      `CHK(wake_request, 1'b0)
      irq_enable[pl[i]] = 1'b0;
    end
    // Internal functions own the pad: I2C on a primary pad, plain alternate
    // on another, and I2C select ignored on a pad still on its interface
    ext_en[2] = 1'b0;
    ext_en[6] = 1'b0;
    alt_out = '0;
    i2c_out = '1;
    i2c_oe_n[2] = 1'b0;
    mode_sel[2*2 +: 2] = CGP_MODE_ALT;
    mode_sel[2*6 +: 2] = CGP_MODE_ALT;
    i2c_select[2] = 1'b1;
    i2c_select[12] = 1'b1;
    step(4);
    `CHK({pad_oe_n[2], pad_out[2], alt_in[2]}, 3'h3)
    `CHK({pad_oe_n[6], pad_out[6]}, 2'h0)
    `CHK({pad_oe_n[12], pad_out[12]}, 2'h0)
    // Reset in mid-run with a pad driving, interrupts pending and a wake raised
    mode_sel[1:0] = CGP_MODE_OUT;
    ext_en[0] = 1'b0;
    irq_enable[3] = 1'b1;
    irq_enable[1] = 1'b1;
    ext_level[3] = 1'b0;
    ext_level[1] = 1'b1;
    sleep_active = 1'b1;
    step(4);
    `CHK({pad_oe_n[0], irq_pending[3], irq_pending[1], wake_request}, 4'h7)
    sys_rst = 1'b1;
    step(1);
    `CHK(pad_oe_n, {N{1'b1}})
    `CHK(irq_any, 1'b0)
    `CHK({irq_pending, wake_request}, {(N+1){1'b0}})
    step(1);
    sys_rst = 1'b0;
    // Pad 2, index 1, still sits high: the emptied chain must not report a false rise
    step(6);
    `CHK({pad_oe_n[0], irq_pending}, {(N+1){1'b0}})
    print_verdict();
  end
endmodule : tb
